// >>> hw/spwc_edge_sync.sv
// Samples wake and button pins at the 32 kHz rate and finds falling edges.
// Assumes slowTick is a one-cycle enable from the standby divider.
`timescale 1ns/10ps
`default_nettype none
module spwc_edge_sync
   import spwc_pkg::*;
#(
   parameter int N = 13
) (
   input  wire logic ref_clk,
   input  wire logic rst_b,
   spwc_sync_if.sync port
);

   logic [N-1:0] meta_q;
   logic [N-1:0] sync_q;
   logic [N-1:0] prev_q;
   logic [N-1:0] fall_q;

   // ----------------------------------------------------------------
   // Per-pin two-stage sampler and edge finder
   // ----------------------------------------------------------------
   for (genvar i = 0; i < N; i++) begin : g_pin
      always_ff @(posedge ref_clk) begin
         if (!rst_b) begin
            meta_q[i] <= 1'b1;
            sync_q[i] <= 1'b1;
            prev_q[i] <= 1'b1;
            fall_q[i] <= 1'b0;
         end else begin
            fall_q[i] <= port.slowTick & prev_q[i] & ~sync_q[i];
            if (port.slowTick) begin
               meta_q[i] <= port.raw[i];
               sync_q[i] <= meta_q[i];
               prev_q[i] <= sync_q[i];
            end
         end
      end
   end

   assign port.level = prev_q;
   assign port.fall  = fall_q;

endmodule
`default_nettype wire

// >>> hw/spwc_pkg.sv
// Constants shared by the soft power wake control block.
// Assumes a 40 MHz reference clock; SLOW_DIV derives from it, the other counts from SLOW_HZ and ms figures.
package spwc_pkg;

   // ----------------------------------------------------------------
   // Register access
   // ----------------------------------------------------------------
   localparam logic [7:0] SPWC_LDN          = 8'h08;
   localparam logic [7:0] ADDR_WAKE_EN1     = 8'hb0;
   localparam logic [7:0] ADDR_WAKE_EN2     = 8'hb1;
   localparam logic [7:0] ADDR_WAKE_STS1    = 8'hb2;
   localparam logic [7:0] ADDR_WAKE_STS2    = 8'hb3;
   localparam logic [7:0] ADDR_OFF_DELAY    = 8'hb8;
   localparam logic [7:0] ADDR_PWR_POWER_WATCHDOG_CONTROL = 8'hf4;
   localparam logic       PORT_INDEX        = 1'b0;
   localparam logic       PORT_DATA         = 1'b1;

   // ----------------------------------------------------------------
   // Field layout and reset values
   // ----------------------------------------------------------------
   localparam int         NUM_WAKE          = 12;
   localparam int         BTN_STS_BIT       = 4;
   localparam int         OFF_EN_BIT        = 7;
   localparam int         SW_OFF_BIT        = 7;
   localparam logic [7:0] WAKE_EN1_RST      = 8'h00;
   localparam logic [7:0] WAKE_EN2_RST      = 8'h80;
   localparam logic [7:0] OFF_DELAY_RST     = 8'h00;
   localparam logic [6:0] PWR_POWER_WATCHDOG_CONTROL_RST  = 7'h00;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int         CLK_HZ            = 40_000_000;
   localparam int         SLOW_HZ           = 32_768;
   localparam int         SLOW_DIV          = CLK_HZ / SLOW_HZ;
   localparam int         HALF_SEC_MS       = 500;
   localparam int         HALF_SEC_SLOW     = SLOW_HZ * HALF_SEC_MS / 1000;
   localparam int         OVR_MIN_MS        = 4000;
   localparam int         OVR_MAX_MS        = 4500;
   localparam logic [3:0] OVR_STEPS         = 4'((OVR_MIN_MS / HALF_SEC_MS) + 1);
   localparam int         OFF_DLY_MAX_MS    = 32_000;
   localparam logic [6:0] OFF_DLY_MAX_STEPS = 7'(OFF_DLY_MAX_MS / HALF_SEC_MS);

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic {
      PWR_OFF = 1'b0,
      PWR_ON  = 1'b1
   } spwc_pwr_t;

   typedef enum logic [1:0] {
      SCI_TO_PIN    = 2'b00,
      SCI_TO_IRQ11  = 2'b01,
      SCI_TO_SERIRQ = 2'b10
   } spwc_sci_sel_t;

endpackage

// >>> hw/spwc_sync_if.sv
// Carrier between the main block and its input synchroniser.
// Assumes both ends run on the same reference clock.
`timescale 1ns/10ps
`default_nettype none
interface spwc_sync_if #(parameter int N = 13);
   logic [N-1:0] raw;
   logic [N-1:0] level;
   logic [N-1:0] fall;
   logic         slowTick;
   modport sync (input raw, input slowTick, output level, output fall);
   modport user (output raw, output slowTick, input level, input fall);
endinterface
`default_nettype wire

// >>> hw/spwc_top.sv
// Soft power wake control: power-state flop, wake and button logic,
// override timer, battery-backed registers and SCI/SMI event routing.
// Assumes rst_b is the battery power-on reset and pins are synchronous.
`timescale 1ns/10ps
`default_nettype none
module spwc_top
   import spwc_pkg::*;
#(
   parameter int HALF_SEC_TICKS = HALF_SEC_SLOW
) (
   input  wire logic                ref_clk,
   input  wire logic                rst_b,
   input  wire logic [NUM_WAKE-1:0] wakeSource,
   input  wire logic                buttonInN,
   input  wire logic                standbyPorPulse,
   input  wire logic                alarmMissedPulse,
   input  wire logic                alarmRememberEnable,
   input  wire logic                standbyPorPowerUp,
   input  wire logic                standbyPorStayOff,
   input  wire logic                overrideEnable,
   input  wire logic                overrideStatusClear,
   input  wire logic                buttonStatusClear,
   input  wire logic                buttonEventEnable,
   input  wire logic                sciRouteEnable,
   input  wire logic                smiRouteEnable,
   input  wire logic [1:0]          sciPinSelect,
   input  wire logic                onStandbyPower,
   input  wire logic                cfgMode,
   input  wire logic [7:0]          cfgLdn,
   input  wire logic [7:0]          cfgAddr,
   input  wire logic                cfgWr,
   input  wire logic                cfgRd,
   input  wire logic [7:0]          cfgWdata,
   output var  logic [7:0]          cfgRdata,
   output var  logic                powerOnRequestN,
   output var  logic                overrideStatus,
   output var  logic                buttonPressStatus,
   output var  logic                sciPinOut,
   output var  logic                irq11Out,
   output var  logic                serIrqSciOut,
   output var  logic                smiOut
);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   localparam int BTN = NUM_WAKE;

   spwc_sync_if #(.N(NUM_WAKE + 1)) syncBus ();

   logic [10:0]         slowCnt_q;
   logic                slowTick_q;
   logic [15:0]         halfCnt_q;
   logic                halfTick_q;
   logic [7:0]          index_q;
   logic [7:0]          wakeEn1_q;
   logic [7:0]          wakeEn2_q;
   logic [7:0]          offDelay_q;
   logic [6:0]          pwrWdtCtrl_q;
   logic [NUM_WAKE-1:0] wakeSts_q;
   logic                btnWakeSts_q;
   spwc_pwr_t           pwr_q;
   spwc_pwr_t           pwr_d;
   logic                armed_q;
   logic [6:0]          offCnt_q;
   logic [3:0]          ovrCnt_q;
   logic                ovrFire_q;
   logic                cfgHit;
   logic [7:0]          regAddr;
   logic                regWr;
   logic                regRd;
   logic [7:0]          readMux;
   logic                swOff;
   logic                btnHeld;
   logic                btnFall;
   logic [NUM_WAKE-1:0] wakeFall;
   logic [NUM_WAKE-1:0] wakeEnAll;
   logic [6:0]          offSteps;
   logic                btnOff;
   logic                onEvent;
   logic                offEvent;
   logic                pmEvent;

   // ----------------------------------------------------------------
   // Standby clock enable and half-second tick
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         slowCnt_q  <= 11'h000;
         slowTick_q <= 1'b0;
      end else if (slowCnt_q == 11'(SLOW_DIV - 1)) begin
         slowCnt_q  <= 11'h000;
         slowTick_q <= 1'b1;
      end else begin
         slowCnt_q  <= slowCnt_q + 11'h001;
         slowTick_q <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         halfCnt_q  <= 16'h0000;
         halfTick_q <= 1'b0;
      end else begin
         halfTick_q <= 1'b0;
         if (slowTick_q) begin
            if (halfCnt_q == 16'(HALF_SEC_TICKS - 1)) begin
               halfCnt_q  <= 16'h0000;
               halfTick_q <= 1'b1;
            end else begin
               halfCnt_q <= halfCnt_q + 16'h0001;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Input sampling
   // ----------------------------------------------------------------
   assign syncBus.raw      = {buttonInN, wakeSource};
   assign syncBus.slowTick = slowTick_q;

   spwc_edge_sync #(.N(NUM_WAKE + 1)) u_sync (
      .ref_clk (ref_clk),
      .rst_b   (rst_b),
      .port    (syncBus.sync)
   );

   assign wakeFall = syncBus.fall[NUM_WAKE-1:0];
   assign btnFall  = syncBus.fall[BTN];
   assign btnHeld  = ~syncBus.level[BTN];

   // ----------------------------------------------------------------
   // Register access decode
   // ----------------------------------------------------------------
   always_comb begin
      cfgHit  = cfgMode && (cfgLdn == SPWC_LDN);
      regAddr = cfgHit ? cfgAddr : index_q;
      regWr   = cfgWr && (cfgHit || (!cfgMode && cfgAddr[0] == PORT_DATA));
      regRd   = cfgRd && (cfgHit || (!cfgMode && cfgAddr[0] == PORT_DATA));
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         index_q <= 8'h00;
      end else if (cfgWr && !cfgMode && cfgAddr[0] == PORT_INDEX) begin
         index_q <= cfgWdata;
      end
   end

   // Battery-backed settings
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         wakeEn1_q    <= WAKE_EN1_RST;
         wakeEn2_q    <= WAKE_EN2_RST;
         offDelay_q   <= OFF_DELAY_RST;
         pwrWdtCtrl_q <= PWR_POWER_WATCHDOG_CONTROL_RST;
      end else if (regWr) begin
         unique case (regAddr)
            ADDR_WAKE_EN1:     wakeEn1_q    <= cfgWdata;
            ADDR_WAKE_EN2:     wakeEn2_q    <= cfgWdata;
            ADDR_OFF_DELAY:    offDelay_q   <= cfgWdata;
            ADDR_PWR_POWER_WATCHDOG_CONTROL: pwrWdtCtrl_q <= cfgWdata[6:0];
            default: ;
         endcase
      end
   end

   assign swOff = regWr && (regAddr == ADDR_PWR_POWER_WATCHDOG_CONTROL)
                  && cfgWdata[SW_OFF_BIT];

   always_comb begin
      readMux = 8'h00;
      unique case (regAddr)
         ADDR_WAKE_EN1:     readMux = wakeEn1_q;
         ADDR_WAKE_EN2:     readMux = wakeEn2_q;
         ADDR_WAKE_STS1:    readMux = wakeSts_q[7:0];
         ADDR_WAKE_STS2:    readMux = {3'h0, btnWakeSts_q, wakeSts_q[NUM_WAKE-1:8]};
         ADDR_OFF_DELAY:    readMux = offDelay_q;
         ADDR_PWR_POWER_WATCHDOG_CONTROL: readMux = {1'b0, pwrWdtCtrl_q};
         default:           readMux = 8'h00;
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         cfgRdata <= 8'h00;
      end else if (cfgRd) begin
         cfgRdata <= (regRd) ? readMux : (cfgMode ? 8'h00 : index_q);
      end
   end

   // ----------------------------------------------------------------
   // Wake status; reading a status register clears what it showed
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         wakeSts_q    <= '0;
         btnWakeSts_q <= 1'b0;
      end else begin
         for (int i = 0; i < NUM_WAKE; i++) begin
            if (wakeFall[i]) begin
               wakeSts_q[i] <= 1'b1;
            end else if (regRd && regAddr == (i < 8 ? ADDR_WAKE_STS1 : ADDR_WAKE_STS2)) begin
               wakeSts_q[i] <= 1'b0;
            end
         end
         if (btnFall) begin
            btnWakeSts_q <= 1'b1;
         end else if (regRd && regAddr == ADDR_WAKE_STS2) begin
            btnWakeSts_q <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Button power-off after the programmed delay
   // ----------------------------------------------------------------
   always_comb begin
      offSteps = (offDelay_q >= 8'(OFF_DLY_MAX_STEPS))
                 ? OFF_DLY_MAX_STEPS : offDelay_q[6:0] + 7'h01;
   end

   // A press that turned power on must be released before it can turn it off
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         armed_q <= 1'b0;
      end else if (pwr_q == PWR_OFF) begin
         armed_q <= 1'b0;
      end else if (!btnHeld) begin
         armed_q <= 1'b1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         offCnt_q <= 7'h00;
      end else if (!btnHeld || !armed_q) begin
         offCnt_q <= 7'h00;
      end else if (halfTick_q && offCnt_q != offSteps) begin
         offCnt_q <= offCnt_q + 7'h01;
      end
   end

   assign btnOff = armed_q && (offCnt_q == offSteps)
                   && wakeEn2_q[OFF_EN_BIT];

   // ----------------------------------------------------------------
   // Override timer
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         ovrCnt_q <= 4'h0;
      end else if (!btnHeld) begin
         ovrCnt_q <= 4'h0;
      end else if (halfTick_q && ovrCnt_q != OVR_STEPS) begin
         ovrCnt_q <= ovrCnt_q + 4'h1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         ovrFire_q <= 1'b0;
      end else begin
         ovrFire_q <= btnHeld && halfTick_q && (ovrCnt_q == OVR_STEPS - 4'h1)
                      && (pwr_q == PWR_ON) && overrideEnable;
      end
   end

   // ----------------------------------------------------------------
   // Power state flop; off events win over on events
   // ----------------------------------------------------------------
   assign wakeEnAll = {wakeEn2_q[NUM_WAKE-9:0], wakeEn1_q};

   always_comb begin
      onEvent  = (|(wakeFall & wakeEnAll)) || btnFall
                 || (alarmMissedPulse && alarmRememberEnable)
                 || (standbyPorPulse && standbyPorPowerUp);
      offEvent = swOff || ovrFire_q
                 || (btnOff && pwr_q == PWR_ON)
                 || (standbyPorPulse && standbyPorStayOff);
      pwr_d    = pwr_q;
      if (offEvent) begin
         pwr_d = PWR_OFF;
      end else if (onEvent) begin
         pwr_d = PWR_ON;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         pwr_q           <= PWR_OFF;
         powerOnRequestN <= 1'b1;
      end else begin
         pwr_q           <= pwr_d;
         powerOnRequestN <= (pwr_d == PWR_OFF);
      end
   end

   // ----------------------------------------------------------------
   // Button and override status
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         buttonPressStatus <= 1'b0;
      end else if (ovrFire_q) begin
         buttonPressStatus <= 1'b0;
      end else if (btnFall) begin
         buttonPressStatus <= 1'b1;
      end else if (buttonStatusClear) begin
         buttonPressStatus <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         overrideStatus <= 1'b0;
      end else if (ovrFire_q) begin
         overrideStatus <= 1'b1;
      end else if (overrideStatusClear) begin
         overrideStatus <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // SCI and SMI routing
   // ----------------------------------------------------------------
   assign pmEvent = buttonPressStatus && buttonEventEnable;

   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         sciPinOut    <= 1'b0;
         irq11Out     <= 1'b0;
         serIrqSciOut <= 1'b0;
         smiOut       <= 1'b0;
      end else begin
         sciPinOut    <= pmEvent && sciRouteEnable
                         && sciPinSelect == SCI_TO_PIN;
         irq11Out     <= pmEvent && sciRouteEnable
                         && sciPinSelect == SCI_TO_IRQ11;
         serIrqSciOut <= pmEvent && sciRouteEnable && !onStandbyPower
                         && sciPinSelect == SCI_TO_SERIRQ;
         smiOut       <= pmEvent && smiRouteEnable;
      end
   end

endmodule
`default_nettype wire

// >>> tb/spwc_supply_model.sv
// Behavioural main supply: power good after a settling delay.
// Assumes the active-low power-on request of the block as its only input besides ref_clk.
`timescale 1ns/10ps
`default_nettype none
module spwc_supply_model #(
   parameter int SETTLE = 8
) (
   input  wire logic ref_clk,
   input  wire logic powerOnRequestN,
   output var  logic powerGood
);
   int settleCnt_q;
   always_ff @(posedge ref_clk) begin
      if (powerOnRequestN) begin
         settleCnt_q <= 0;
         powerGood   <= 1'b0;
      end else if (settleCnt_q < SETTLE) begin
         settleCnt_q <= settleCnt_q + 1;
      end else begin
         powerGood   <= 1'b1;
      end
   end
endmodule
`default_nettype wire

// >>> tb/spwc_top_sva.sv
// Concurrent checks on the soft power wake control top ports.
// Assumes one clock domain and the synchronous active-low reset.
`timescale 1ns/10ps
`default_nettype none
module spwc_top_sva
   import spwc_pkg::*;
#(
   parameter int HALF_SEC_TICKS = HALF_SEC_SLOW
) (
   input  wire logic       ref_clk,
   input  wire logic       rst_b,
   input  wire logic       buttonInN,
   input  wire logic       standbyPorPulse,
   input  wire logic       alarmMissedPulse,
   input  wire logic       alarmRememberEnable,
   input  wire logic       standbyPorPowerUp,
   input  wire logic       standbyPorStayOff,
   input  wire logic       overrideStatusClear,
   input  wire logic       buttonEventEnable,
   input  wire logic       smiRouteEnable,
   input  wire logic       onStandbyPower,
   input  wire logic       cfgMode,
   input  wire logic [7:0] cfgLdn,
   input  wire logic [7:0] cfgAddr,
   input  wire logic       cfgWr,
   input  wire logic       cfgRd,
   input  wire logic [7:0] cfgWdata,
   input  wire logic [7:0] cfgRdata,
   input  wire logic       powerOnRequestN,
   input  wire logic       overrideStatus,
   input  wire logic       buttonPressStatus,
   input  wire logic       serIrqSciOut,
   input  wire logic       smiOut
);
   localparam int MIN_HELD = 8 * HALF_SEC_TICKS * SLOW_DIV - SLOW_DIV;
   int   heldCnt_q;
   int   relCnt_q;
   logic swOff;
   assign swOff = cfgWr && cfgMode && cfgLdn == SPWC_LDN && cfgAddr == ADDR_PWR_POWER_WATCHDOG_CONTROL
                  && cfgWdata[SW_OFF_BIT];
   // Button hold length, kept across releases shorter than the sampler delay
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         heldCnt_q <= 0;
         relCnt_q  <= 0;
      end else if (!buttonInN) begin
         heldCnt_q <= heldCnt_q + 1;
         relCnt_q  <= 0;
      end else begin
         relCnt_q  <= relCnt_q + 1;
         if (relCnt_q > 4 * SLOW_DIV) begin
            heldCnt_q <= 0;
         end
      end
   end
   // ----------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_b);
   AST_SW_OFF: assert property (swOff |=> powerOnRequestN)
      else $error("soft off ignored");
   AST_POR_ON: assert property (standbyPorPulse && standbyPorPowerUp && !standbyPorStayOff
      && !swOff |-> ##[1:2] !powerOnRequestN) else $error("no standby power-up");
   AST_POR_OFF: assert property (standbyPorPulse && standbyPorStayOff && powerOnRequestN
      && !alarmMissedPulse |=> powerOnRequestN [*2]) else $error("stay-off powered up");
   AST_ALARM_ON: assert property (alarmMissedPulse && alarmRememberEnable && !swOff
      |-> ##[1:2] !powerOnRequestN) else $error("no alarm power-up");
   AST_OVR_STICKY: assert property (overrideStatus && !overrideStatusClear |=> overrideStatus)
      else $error("override status dropped");
   AST_OVR_CLEAR: assert property (overrideStatusClear |=> !overrideStatus)
      else $error("override clear ignored");
   AST_OVR_EFFECT: assert property ($rose(overrideStatus) |-> !buttonPressStatus
      && powerOnRequestN) else $error("override effect missing");
   AST_OVR_TIME: assert property ($rose(overrideStatus) |-> heldCnt_q >= MIN_HELD)
      else $error("override too early");
   AST_SMI: assert property (buttonPressStatus && buttonEventEnable && smiRouteEnable |=> smiOut)
      else $error("SMI not raised");
   AST_SMI_OFF: assert property (!smiRouteEnable |=> !smiOut)
      else $error("stray SMI");
   AST_SERIRQ: assert property (onStandbyPower |=> !serIrqSciOut)
      else $error("serial IRQ on standby");
   AST_LDN: assert property (cfgRd && cfgMode && cfgLdn != SPWC_LDN |=> cfgRdata == 8'h00)
      else $error("foreign device read data");
   COV_ON: cover property ($fell(powerOnRequestN));
   COV_OVR: cover property ($rose(overrideStatus));
   COV_SMI: cover property ($rose(smiOut));
endmodule
bind spwc_top spwc_top_sva #(.HALF_SEC_TICKS(HALF_SEC_TICKS)) spwc_top_sva_inst (.*);
`default_nettype wire

// >>> tb/testbench.sv
// Self-checking bench for the soft power wake control top.
// Assumes a 40 MHz clock and a shortened half-second count.
`timescale 1ns/10ps
`default_nettype none
module testbench;
   import spwc_pkg::*;
   localparam int H  = 4;
   localparam int HC = H * SLOW_DIV;
   logic                ref_clk = 1'b0;
   logic                rst_b, buttonInN, standbyPorPulse, alarmMissedPulse, alarmRememberEnable;
   logic                standbyPorPowerUp, standbyPorStayOff, overrideEnable, overrideStatusClear;
   logic                buttonStatusClear, buttonEventEnable, sciRouteEnable, smiRouteEnable;
   logic                onStandbyPower, cfgMode, cfgWr, cfgRd, powerGood;
   logic                powerOnRequestN, overrideStatus, buttonPressStatus, sciPinOut, irq11Out;
   logic                serIrqSciOut, smiOut;
   logic [NUM_WAKE-1:0] wakeSource;
   logic [1:0]          sciPinSelect;
   logic [7:0]          cfgLdn, cfgAddr, cfgWdata, cfgRdata;
   logic [31:0]         seed = 32'hc1de;
   logic [7:0]          regs [4] = '{ADDR_WAKE_EN1, ADDR_WAKE_EN2, ADDR_OFF_DELAY, ADDR_PWR_POWER_WATCHDOG_CONTROL};
   logic [2:0]          tab [4] = '{3'b100, 3'b010, 3'b001, 3'b000};
   int                  n_fail = 0, total_checks = 0, cyc = 0, n;
   int                  mdl [int];
   always #12.5 ref_clk = ~ref_clk;
   spwc_top #(.HALF_SEC_TICKS(H)) spwc_top_inst (.*);
   spwc_supply_model spwc_supply_model_inst (.ref_clk, .powerOnRequestN, .powerGood);
   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic [7:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[7:0];
   endfunction
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic md, input logic [7:0] ldn, a, d, input logic wr);
      @(negedge ref_clk);
      {cfgMode, cfgLdn, cfgAddr, cfgWdata, cfgWr, cfgRd} = {md, ldn, a, d, wr, !wr};
      @(negedge ref_clk);
      {cfgWr, cfgRd} = 2'b00;
   endtask
   // Config mode write, or index then data port write
   task automatic wr(input logic md, input logic [7:0] a, d);
      if (md) begin
         bus(1'b1, SPWC_LDN, a, d, 1'b1);
      end else begin
         bus(1'b0, 8'h00, 8'h00, a, 1'b1);
         bus(1'b0, 8'h00, 8'h01, d, 1'b1);
      end
      mdl[a] = (a == ADDR_PWR_POWER_WATCHDOG_CONTROL) ? {1'b0, d[6:0]} : d;
   endtask
   task automatic rd(input logic [7:0] a, e);
      bus(1'b1, SPWC_LDN, a, 8'h00, 1'b0);
      chk(cfgRdata, e);
   endtask
   task automatic pulse(ref logic s);
      @(negedge ref_clk);
      s = 1'b1;
      @(negedge ref_clk);
      s = 1'b0;
   endtask
   task automatic waitPwr(input logic lvl, input int lim);
      n = 0;
      while (powerOnRequestN !== lvl && n < lim) begin
         @(negedge ref_clk);
         n++;
      end
      chk(powerOnRequestN, lvl);
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 99000) begin
         n_fail++;
         give_verdict();
      end
   end
   // ----------------------------------------------------------------
   // Sequence
   // ----------------------------------------------------------------
   initial begin
      {rst_b, buttonInN, standbyPorPulse, alarmMissedPulse, alarmRememberEnable} = 5'b01000;
      {standbyPorPowerUp, standbyPorStayOff, overrideEnable, overrideStatusClear} = 4'h0;
      {buttonStatusClear, buttonEventEnable, sciRouteEnable, smiRouteEnable, onStandbyPower} = 5'h0;
      {cfgMode, cfgWr, cfgRd, cfgLdn, cfgAddr, cfgWdata, sciPinSelect} = '0;
      wakeSource = '1;
      mdl = '{32'hb0: 8'h00, 32'hb1: 8'h80, 32'hb8: 8'h00, 32'hf4: 8'h00};
      repeat (8) @(negedge ref_clk);
      rst_b = 1'b1;
      foreach (mdl[a]) rd(8'(a), 8'(mdl[a]));
      rd(8'hb4, 8'h00);
      bus(1'b1, 8'h07, ADDR_WAKE_EN1, 8'h00, 1'b0);
      chk(cfgRdata, 8'h00);
      for (int i = 0; i < 8; i++) begin
         wr(i[0], regs[i[1:0]], rnd());
         rd(regs[i[1:0]], 8'(mdl[regs[i[1:0]]]));
      end
      bus(1'b0, 8'h00, 8'h00, 8'h00, 1'b0);
      chk(cfgRdata, ADDR_OFF_DELAY);
      wr(1'b1, ADDR_WAKE_EN1, 8'h00);
      wr(1'b1, ADDR_OFF_DELAY, 8'h01);
      $display("test registers finished");
      wakeSource[0] = 1'b0;
      repeat (5 * SLOW_DIV) @(negedge ref_clk);
      chk(powerOnRequestN, 1'b1);
      rd(ADDR_WAKE_STS1, 8'h01);
      rd(ADDR_WAKE_STS1, 8'h00);
      wakeSource = '1;
      wr(1'b1, ADDR_WAKE_EN2, 8'h82);
      wakeSource[9] = 1'b0;
      waitPwr(1'b0, 5 * SLOW_DIV);
      rd(ADDR_WAKE_STS2, 8'h02);
      repeat (8) @(negedge ref_clk);
      chk(powerGood, 1'b1);
      wakeSource = '1;
      wr(1'b1, ADDR_PWR_POWER_WATCHDOG_CONTROL, 8'h80);
      chk(powerOnRequestN, 1'b1);
      rd(ADDR_PWR_POWER_WATCHDOG_CONTROL, 8'h00);
      $display("test wake finished");
      for (int k = 0; k < 4; k++) begin
         {standbyPorPowerUp, standbyPorStayOff, alarmRememberEnable} = tab[k];
         if (k < 2) begin
            pulse(standbyPorPulse);
         end else begin
            pulse(alarmMissedPulse);
         end
         repeat (2) @(negedge ref_clk);
         chk(powerOnRequestN, k[0]);
         wr(1'b1, ADDR_PWR_POWER_WATCHDOG_CONTROL, 8'h80);
      end
      {standbyPorPowerUp, standbyPorStayOff, alarmRememberEnable} = 3'b000;
      $display("test pulses finished");
      {buttonEventEnable, sciRouteEnable, smiRouteEnable} = 3'b111;
      buttonInN = 1'b0;
      waitPwr(1'b0, 5 * SLOW_DIV);
      chk(buttonPressStatus, 1'b1);
      rd(ADDR_WAKE_STS2, 8'h10);
      for (int s = 0; s < 5; s++) begin
         sciPinSelect = (s > 2) ? 2'h2 : 2'(s);
         onStandbyPower = (s > 2);
         smiRouteEnable = (s < 4);
         sciRouteEnable = (s != 1);
         repeat (2) @(negedge ref_clk);
         chk({sciPinOut, irq11Out, serIrqSciOut, smiOut}, {sciPinSelect == 2'h0,
             sciPinSelect == 2'h1 && sciRouteEnable, sciPinSelect == 2'h2 && !onStandbyPower,
             smiRouteEnable});
      end
      buttonInN = 1'b1;
      pulse(buttonStatusClear);
      chk(buttonPressStatus, 1'b0);
      repeat (4 * SLOW_DIV) @(negedge ref_clk);
      $display("test button finished");
      buttonInN = 1'b0;
      waitPwr(1'b1, 3 * HC);
      chk(n >= HC + 2 * SLOW_DIV && n <= 2 * HC + 4 * SLOW_DIV, 1'b1);
      buttonInN = 1'b1;
      repeat (4 * SLOW_DIV) @(negedge ref_clk);
      $display("test button off finished");
      wr(1'b1, ADDR_WAKE_EN2, 8'h00);
      {overrideEnable, standbyPorPowerUp} = 2'b11;
      pulse(standbyPorPulse);
      standbyPorPowerUp = 1'b0;
      buttonInN = 1'b0;
      waitPwr(1'b1, 10 * HC);
      chk(n >= 8 * HC && n <= 9 * HC + 4 * SLOW_DIV, 1'b1);
      chk({overrideStatus, buttonPressStatus}, 2'b10);
      buttonInN = 1'b1;
      pulse(overrideStatusClear);
      chk(overrideStatus, 1'b0);
      $display("test override finished");
      give_verdict();
   end
endmodule
`default_nettype wire
